// File: logic/sbsr_event_reg.sv
// Package for the status byte block and its sticky event register leaf.
package sbsr_pkg;
   localparam int SBSR_STB_W = 8;
   localparam int SBSR_ESR_W = 8;
   localparam int SBSR_OPER_W = 16;
   localparam int SBSR_RSP_W = 16;
   // Bit positions inside the status byte.
   localparam int SBSR_EAV = 2;
   localparam int SBSR_MAV = 4;
   localparam int SBSR_ESB = 5;
   localparam int SBSR_MSS = 6;
   localparam int SBSR_OSB = 7;
   // Positions that may take part in a service request.
   localparam logic [7:0] SBSR_REQ_BITS = 8'hb4;
   // Positions without a function.
   localparam logic [7:0] SBSR_UNDEF_BITS = 8'h0b;
   localparam logic [7:0] SBSR_SRM_RST = 8'h00;
   localparam logic [7:0] SBSR_STB_RST = 8'h00;
   localparam logic [15:0] SBSR_RSP_RST = 16'h0000;
endpackage

`timescale 1ns/1ps

// Sticky event register with enable part and sum bit.
module sbsr_event_reg #(
   parameter int W = 8
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Event sources, one-cycle pulses or levels.
   input wire logic [W-1:0] set_ev,
   // Read of the event part, clears it.
   input wire logic rd_clr,
   // Enable part write.
   input wire logic en_wr,
   input wire logic [W-1:0] en_data,
   // State.
   output logic [W-1:0] event_q,
   output logic [W-1:0] enable_q,
   output logic sum
);
   logic [W-1:0] event_d;

   // clear on read
   // A set arriving with the read wins so no event is lost.
   assign event_d = (event_q & ~{W{rd_clr}}) | set_ev;
   assign sum = |(event_q & enable_q);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         event_q <= '0;
         enable_q <= '0;
      end else begin
         event_q <= event_d;
         if (en_wr) begin
            enable_q <= en_data;
         end
      end
   end
endmodule // sbsr_event_reg

// File: logic/sbsr_status_byte.sv
// Status byte, service request mask and service request generation.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module sbsr_status_byte (
   // Clock and reset.
   input wire logic clk,
   input wire logic arst_n,
   // Status sources.
   input wire logic err_entry,
   input wire logic err_nonempty,
   input wire logic msg_avail,
   input wire logic [sbsr_pkg::SBSR_ESR_W-1:0] esr_set,
   input wire logic [sbsr_pkg::SBSR_OPER_W-1:0] oper_set,
   // Mask commands.
   input wire logic srm_wr,
   input wire logic [sbsr_pkg::SBSR_STB_W-1:0] srm_data,
   input wire logic srm_rd,
   input wire logic ese_wr,
   input wire logic [sbsr_pkg::SBSR_ESR_W-1:0] ese_data,
   input wire logic oper_en_wr,
   input wire logic [sbsr_pkg::SBSR_OPER_W-1:0] oper_en_data,
   // Read commands.
   input wire logic stb_rd,
   input wire logic poll,
   input wire logic esr_rd,
   input wire logic oper_rd,
   // Answers and state.
   output logic rsp_valid_q,
   output logic [sbsr_pkg::SBSR_RSP_W-1:0] rsp_data_q,
   output logic [sbsr_pkg::SBSR_STB_W-1:0] status_byte_q,
   output logic [sbsr_pkg::SBSR_STB_W-1:0] service_request_mask_q,
   output logic srq_q
);
   import sbsr_pkg::*;

   // Keeps only positions allowed to request service.
   function automatic logic [7:0] sbsr_gate(input logic [7:0] v,
                                            input logic [7:0] m);
      sbsr_gate = v & m & SBSR_REQ_BITS;
   endfunction

   logic [SBSR_ESR_W-1:0] esr_ev;
   logic [SBSR_OPER_W-1:0] oper_ev;
   logic [SBSR_OPER_W-1:0] oper_en;
   logic esr_sum;
   logic oper_sum;
   logic [7:0] stb_base;
   logic [7:0] stb_w;
   logic [7:0] rise_w;
   logic mss_w;
   logic srq_set;
   logic srq_d;
   logic take_poll;
   logic take_stb;
   logic take_srm;
   logic take_esr;
   logic take_oper;
   logic rsp_valid_d;
   logic [SBSR_RSP_W-1:0] rsp_data_d;
   logic [7:0] stb_prev_q;

   ////////////////////////////////////////////////////////////////////////
   // lower registers cleared when read
   sbsr_event_reg #(.W(SBSR_ESR_W)) u_esr (
      .clk(clk),
      .arst_n(arst_n),
      .set_ev(esr_set),
      .rd_clr(take_esr),
      .en_wr(ese_wr),
      .en_data(ese_data),
      .event_q(esr_ev),
      .enable_q(),
      .sum(esr_sum)
   );

   sbsr_event_reg #(.W(SBSR_OPER_W)) u_oper (
      .clk(clk),
      .arst_n(arst_n),
      .set_ev(oper_set),
      .rd_clr(take_oper),
      .en_wr(oper_en_wr),
      .en_data(oper_en_data),
      .event_q(oper_ev),
      .enable_q(oper_en),
      .sum(oper_sum)
   );

   ////////////////////////////////////////////////////////////////////////
   // Status byte assembly.
   always_comb begin
      stb_base = SBSR_STB_RST;
      stb_base[SBSR_EAV] = err_nonempty | err_entry;
      stb_base[SBSR_MAV] = msg_avail;
      stb_base[SBSR_ESB] = esr_sum;
      stb_base[SBSR_OSB] = oper_sum;
   end

   assign mss_w = |sbsr_gate(stb_base, service_request_mask_q);
   assign stb_w = stb_base | ({7'h00, mss_w} << SBSR_MSS);

   // each error entry counts as a fresh rise
   // The mss bit is kept out so it cannot re-trigger itself.
   assign rise_w = (stb_w & ~stb_prev_q) | ({7'h00, err_entry} << SBSR_EAV);
   assign srq_set = |sbsr_gate(rise_w, service_request_mask_q);
   // A serial poll drops the request, but a new rise in the same cycle wins.
   assign srq_d = srq_set | (srq_q & ~poll);

   ////////////////////////////////////////////////////////////////////////
   // One read served per cycle, poll first; lower ones are dropped.
   assign take_poll = poll;
   assign take_stb = stb_rd & ~poll;
   assign take_srm = srm_rd & ~poll & ~stb_rd;
   assign take_esr = esr_rd & ~poll & ~stb_rd & ~srm_rd;
   assign take_oper = oper_rd & ~poll & ~stb_rd & ~srm_rd & ~esr_rd;
   assign rsp_valid_d = take_poll | take_stb | take_srm | take_esr
                        | take_oper;

   // query and poll give current byte
   always_comb begin
      rsp_data_d = SBSR_RSP_RST;
      if (take_poll || take_stb) begin
         rsp_data_d[7:0] = stb_w;
      end else if (take_srm) begin
         rsp_data_d[7:0] = service_request_mask_q;
      end else if (take_esr) begin
         rsp_data_d[7:0] = esr_ev;
      end else if (take_oper) begin
         rsp_data_d = oper_ev;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stb_prev_q <= SBSR_STB_RST;
         status_byte_q <= SBSR_STB_RST;
         srq_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_data_q <= SBSR_RSP_RST;
      end else begin
         stb_prev_q <= stb_w;
         status_byte_q <= stb_w;
         srq_q <= srq_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_data_q <= rsp_data_d;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         service_request_mask_q <= SBSR_SRM_RST;
      end else if (srm_wr) begin
         service_request_mask_q <= srm_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   mss_summary_a: assert property (
      status_byte_q[SBSR_MSS] ==
      |(status_byte_q & $past(service_request_mask_q) & SBSR_REQ_BITS))
      else $error("summary bit disagrees with masked status");

   undef_zero_a: assert property (
      (status_byte_q & SBSR_UNDEF_BITS) == 8'h00)
      else $error("undefined status bit set");

   srq_rise_a: assert property (
      srq_set |=> srq_q)
      else $error("enabled rise gave no service request");

   srq_cause_a: assert property (
      $rose(srq_q) |-> $past(|((rise_w & ~({7'h00, 1'b1} << SBSR_MSS))
         & service_request_mask_q & SBSR_REQ_BITS)))
      else $error("service request without enabled rise");

   err_each_a: assert property (
      err_entry && service_request_mask_q[SBSR_EAV] |=> srq_q)
      else $error("error entry gave no service request");

   err_bit_a: assert property (
      err_entry |=> status_byte_q[SBSR_EAV])
      else $error("error bit not set on entry");

   mav_bit_a: assert property (
      1'b1 |=> status_byte_q[SBSR_MAV] == $past(msg_avail))
      else $error("message available bit wrong");

   poll_data_a: assert property (
      poll |=> rsp_valid_q && rsp_data_q[7:0] == $past(stb_w))
      else $error("poll answer is not the status byte");

   mask_rb_a: assert property (
      srm_wr ##1 (srm_rd && !poll && !stb_rd && !srm_wr)
      |=> rsp_valid_q && rsp_data_q[7:0] == $past(srm_data, 2))
      else $error("mask read back wrong");

   esr_clear_a: assert property (
      take_esr && esr_set == 8'h00 ##1 esr_set == 8'h00
      |=> !status_byte_q[SBSR_ESB])
      else $error("event summary not cleared by read");

   oper_sum_a: assert property (
      |(oper_set & oper_en) && !oper_en_wr ##1 !oper_en_wr
      |=> status_byte_q[SBSR_OSB])
      else $error("operation summary not set");

   esb_sum_a: assert property (
      esr_sum |=> status_byte_q[SBSR_ESB])
      else $error("event status summary not set");

   poll_srq_c: cover property (srq_q ##[1:20] poll);
   err_twice_c: cover property (err_entry && srq_q ##[1:20] err_entry);
   esr_read_c: cover property (esr_sum ##[1:20] take_esr);
endmodule // sbsr_status_byte

// File: test/sbsr_ctrl_model.sv
// Remote controller model that issues commands and collects answers.
`timescale 1ns/1ps

module sbsr_ctrl_model (
   // Clock.
   input wire logic clk,
   // Commands.
   output logic srm_wr,
   output logic [7:0] srm_data,
   output logic srm_rd,
   output logic stb_rd,
   output logic poll,
   // Answers.
   input wire logic rsp_valid_q,
   input wire logic [15:0] rsp_data_q
);
   initial begin
      {srm_wr, srm_rd, stb_rd, poll} = 4'h0;
      srm_data = 8'h00;
   end
   ////////////////////////////////////////////////////////////////////////
   // mask write command.
   task automatic set_mask(input logic [7:0] m);
      @(negedge clk);
      srm_wr = 1'b1;
      srm_data = m;
      @(negedge clk);
      srm_wr = 1'b0;
      // Released data is inverted so a stale value never looks valid.
      srm_data = ~m;
   endtask
   // mask write with its query in the very next cycle.
   task automatic set_and_ask(input logic [7:0] m, output logic [7:0] b);
      @(negedge clk);
      srm_wr = 1'b1;
      srm_data = m;
      @(negedge clk);
      srm_wr = 1'b0;
      srm_data = ~m;
      srm_rd = 1'b1;
      @(negedge clk);
      srm_rd = 1'b0;
      b = (rsp_valid_q === 1'b1) ? rsp_data_q[7:0] : 8'hxx;
   endtask
   // query, poll or mask query; the answer stands one cycle.
   task automatic ask(input int k, output logic [7:0] b);
      @(negedge clk);
      stb_rd = (k == 0);
      poll = (k == 1);
      srm_rd = (k == 2);
      @(negedge clk);
      {stb_rd, poll, srm_rd} = 3'h0;
      b = (rsp_valid_q === 1'b1) ? rsp_data_q[7:0] : 8'hxx;
   endtask
endmodule // sbsr_ctrl_model

// File: test/test_status_byte_service_request.sv
// Bench for the status byte and service request block.
`timescale 1ns/1ps

module test_status_byte_service_request;
   logic clk, arst_n, err_entry, err_nonempty, msg_avail, srq_q;
   logic ese_wr, oper_en_wr, esr_rd, oper_rd, srm_wr, srm_rd, stb_rd, poll;
   logic [7:0] esr_set, ese_data, srm_data, b;
   logic [7:0] status_byte_q, service_request_mask_q;
   logic [15:0] oper_set, oper_en_data, rsp_data_q;
   logic rsp_valid_q;
   int fails, samples_checked;

   sbsr_status_byte dut_u (.clk(clk), .arst_n(arst_n),
      .err_entry(err_entry), .err_nonempty(err_nonempty),
      .msg_avail(msg_avail), .esr_set(esr_set), .oper_set(oper_set),
      .srm_wr(srm_wr), .srm_data(srm_data), .srm_rd(srm_rd),
      .ese_wr(ese_wr), .ese_data(ese_data), .oper_en_wr(oper_en_wr),
      .oper_en_data(oper_en_data), .stb_rd(stb_rd), .poll(poll),
      .esr_rd(esr_rd), .oper_rd(oper_rd), .rsp_valid_q(rsp_valid_q),
      .rsp_data_q(rsp_data_q), .status_byte_q(status_byte_q),
      .service_request_mask_q(service_request_mask_q), .srq_q(srq_q));
   sbsr_ctrl_model ctl_u (.clk(clk), .srm_wr(srm_wr), .srm_data(srm_data),
      .srm_rd(srm_rd), .stb_rd(stb_rd), .poll(poll),
      .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic pulse_err;
      err_entry = 1'b1;
      cyc(1);
      err_entry = 1'b0;
      cyc(2);
   endtask
   task automatic t_mask;
      ctl_u.ask(2, b);
      chk("mask reset", 8'h00, b);
      ctl_u.set_mask(8'hff);
      ctl_u.ask(2, b);
      chk("mask all", 8'hff, b);
      ctl_u.set_and_ask(8'h5a, b);
      chk("mask back to back", 8'h5a, b);
      chk("mask port", 8'h5a, service_request_mask_q);
      ctl_u.set_mask(8'h40);
      msg_avail = 1'b1;
      cyc(3);
      chk("srq bit6 only", 1'b0, srq_q);
      chk("byte mav", 8'h10, status_byte_q);
      ctl_u.ask(0, b);
      chk("query mav", 8'h10, b);
      $display("test mask done");
   endtask
   task automatic t_mav;
      msg_avail = 1'b0;
      ctl_u.set_mask(8'h10);
      msg_avail = 1'b1;
      cyc(3);
      chk("srq mav", 1'b1, srq_q);
      chk("byte mss", 8'h50, status_byte_q);
      ctl_u.ask(1, b);
      chk("poll byte", 8'h50, b);
      chk("srq cleared", 1'b0, srq_q);
      msg_avail = 1'b0;
      cyc(3);
      chk("byte idle", 8'h00, status_byte_q);
      $display("test mav done");
   endtask
   task automatic t_err;
      ctl_u.set_mask(8'h04);
      err_nonempty = 1'b1;
      pulse_err();
      chk("byte err", 8'h44, status_byte_q);
      chk("srq err", 1'b1, srq_q);
      ctl_u.ask(1, b);
      chk("poll err", 8'h44, b);
      chk("srq poll", 1'b0, srq_q);
      pulse_err();
      chk("srq again", 1'b1, srq_q);
      pulse_err();
      pulse_err();
      chk("srq held", 1'b1, srq_q);
      ctl_u.ask(1, b);
      chk("poll err again", 8'h44, b);
      err_nonempty = 1'b0;
      $display("test err done");
   endtask
   task automatic t_ev;
      ctl_u.set_mask(8'h00);
      ese_wr = 1'b1;
      oper_en_wr = 1'b1;
      cyc(1);
      ese_wr = 1'b0;
      oper_en_wr = 1'b0;
      esr_set = 8'h03;
      oper_set = 16'h0001;
      cyc(1);
      esr_set = 8'h00;
      oper_set = 16'h0000;
      cyc(3);
      chk("byte sums", 8'ha0, status_byte_q);
      esr_rd = 1'b1;
      cyc(1);
      esr_rd = 1'b0;
      chk("esr answer", 16'h0003, rsp_data_q);
      oper_rd = 1'b1;
      cyc(1);
      oper_rd = 1'b0;
      chk("oper answer", 16'h0001, rsp_data_q);
      cyc(3);
      chk("byte cleared", 8'h00, status_byte_q);
      $display("test events done");
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      fails = 0;
      samples_checked = 0;
      arst_n = 1'b0;
      {err_entry, err_nonempty, msg_avail, ese_wr} = 4'h0;
      {oper_en_wr, esr_rd, oper_rd} = 3'h0;
      esr_set = 8'h00;
      oper_set = 16'h0000;
      ese_data = 8'h01;
      oper_en_data = 16'h0001;
      repeat (4) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      chk("srq reset", 1'b0, srq_q);
      t_mask();
      t_mav();
      t_err();
      t_ev();
      report_and_stop();
   end
   // The tests need about sixty cycles; this is ample margin.
   initial begin
      repeat (2000) @(posedge clk);
      fails++;
      report_and_stop();
   end
endmodule // test_status_byte_service_request
